/* File: eewr_pkg.sv */
// Package for the byte-wide nonvolatile memory write controller
package eewr_pkg;
    localparam int CLK_MHZ = 100;
    localparam int WRITE_MS = 10;
    localparam int STROBE_NS = 100;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_CYC = WRITE_MS * 1000 * CLK_MHZ;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_CHIP_ERASE = 2'h2;
    localparam logic [DATA_W-1:0] ERASE_FILL = 8'hFF;

    typedef enum logic [2:0] {
        EEWR_IDLE = 3'b000,
        EEWR_STROBE = 3'b001,
        EEWR_WAIT_BUSY = 3'b010,
        EEWR_WAIT_READY = 3'b011,
        EEWR_READ = 3'b100,
        EEWR_TIMED = 3'b101
    } eewr_state_e;

    typedef struct packed {
        logic [1:0] op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eewr_req_s;
endpackage

/* File: eewr_sync.sv */
// Three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module eewr_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic async_in,
    output logic level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Chain; first stage feeds only the second
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            level_out <= RESET_VAL;
        else if (s2_r == s3_r)
            level_out <= s3_r;
    end
endmodule

/* File: eewr_host.sv */
// Host-side write controller driving a self-timed byte-wide memory
// Functional notes
// - Host starts a byte write with a short 100 ns bus write strobe.
// - Host accesses the device again only after ready returns high.
// - Host learns completion by polling or interrupt on the ready line.
// - Without on-chip sequencing, host latches and times 10 ms itself.
`timescale 1ns/100ps
module eewr_host #(
    parameter int ADDR_W = eewr_pkg::ADDR_W,
    parameter int DATA_W = eewr_pkg::DATA_W,
    parameter int WRITE_CYC = eewr_pkg::WRITE_CYC,
    parameter int BUSY_WAIT_CYC = 16,
    parameter int READ_CYC = 4
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire logic [1:0] req_op_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_data_in,
    input wire logic self_timed_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [DATA_W-1:0] rd_data_out,
    output logic write_done_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe_out,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic mem_ce_n_out,
    output logic mem_we_n_out,
    output logic mem_oe_n_out,
    output logic mem_erase_out,
    input wire logic mem_ready_in
);
    localparam int CNT_W = $clog2(WRITE_CYC + 1) + 1;

    // Elaboration checks; the shared counter is sized from WRITE_CYC, so every other count must fit under it
    if (ADDR_W != eewr_pkg::ADDR_W || DATA_W != eewr_pkg::DATA_W)
        $error("Address or data width differs from the request struct");
    if (WRITE_CYC < 1 || READ_CYC < 2 || BUSY_WAIT_CYC < 5)
        $error("Timing counts too small for the sequencer");
    if (READ_CYC > WRITE_CYC || BUSY_WAIT_CYC > WRITE_CYC || eewr_pkg::STROBE_CYC > WRITE_CYC)
        $error("Timing counts too large for the shared counter");

    // Saturating decrement used by every timer
    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        dec_sat = (v == '0) ? '0 : v - 1'b1;
    endfunction

    eewr_pkg::eewr_state_e state_r;
    eewr_pkg::eewr_req_s req_r;
    logic [CNT_W-1:0] cnt_r;
    logic timed_mode_r;
    logic ready_sync;

    eewr_sync #(
        .RESET_VAL(1'b1)
    ) u_ready_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(mem_ready_in),
        .level_out(ready_sync)
    );

    // Sequencer; requests only accepted once the line is ready
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_r <= eewr_pkg::EEWR_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                eewr_pkg::EEWR_IDLE:
                    if (req_valid_in && ready_sync)
                    begin
                        if (req_op_in == eewr_pkg::OP_READ)
                        begin
                            state_r <= eewr_pkg::EEWR_READ;
                            cnt_r <= CNT_W'(READ_CYC);
                        end
                        else
                        begin
                            state_r <= eewr_pkg::EEWR_STROBE;
                            cnt_r <= CNT_W'(eewr_pkg::STROBE_CYC);
                        end
                    end
                eewr_pkg::EEWR_STROBE:
                    if (cnt_r == CNT_W'(1))
                    begin
                        if (timed_mode_r)
                        begin
                            state_r <= eewr_pkg::EEWR_TIMED;
                            cnt_r <= CNT_W'(WRITE_CYC);
                        end
                        else
                        begin
                            state_r <= eewr_pkg::EEWR_WAIT_BUSY;
                            cnt_r <= CNT_W'(BUSY_WAIT_CYC);
                        end
                    end
                    else
                        cnt_r <= dec_sat(cnt_r);
                eewr_pkg::EEWR_WAIT_BUSY:
                    if (!ready_sync)
                        state_r <= eewr_pkg::EEWR_WAIT_READY;
                    else if (cnt_r == '0)
                        state_r <= eewr_pkg::EEWR_IDLE;
                    else
                        cnt_r <= dec_sat(cnt_r);
                eewr_pkg::EEWR_WAIT_READY:
                    if (ready_sync)
                        state_r <= eewr_pkg::EEWR_IDLE;
                eewr_pkg::EEWR_TIMED:
                    if (cnt_r == CNT_W'(1))
                        state_r <= eewr_pkg::EEWR_IDLE;
                    else
                        cnt_r <= dec_sat(cnt_r);
                eewr_pkg::EEWR_READ:
                    if (cnt_r == CNT_W'(1))
                        state_r <= eewr_pkg::EEWR_IDLE;
                    else
                        cnt_r <= dec_sat(cnt_r);
                default:
                    state_r <= eewr_pkg::EEWR_IDLE;
            endcase
        end
    end

    // Request latch; address and data held for the whole write
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            req_r <= '0;
            timed_mode_r <= 1'b0;
        end
        else if (state_r == eewr_pkg::EEWR_IDLE && req_valid_in && ready_sync)
        begin
            req_r.op <= req_op_in;
            req_r.addr <= req_addr_in;
            req_r.data <= (req_op_in == eewr_pkg::OP_CHIP_ERASE) ? eewr_pkg::ERASE_FILL : req_data_in;
            timed_mode_r <= self_timed_in;
        end
    end

    // Memory pins; timed mode keeps the pins on for the whole pulse
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            mem_addr_out <= '0;
            mem_data_out <= '0;
            mem_data_oe_out <= 1'b0;
            mem_ce_n_out <= 1'b1;
            mem_we_n_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
            mem_erase_out <= 1'b0;
        end
        else
        begin
            mem_addr_out <= req_r.addr;
            mem_data_out <= req_r.data;
            mem_erase_out <= (req_r.op == eewr_pkg::OP_CHIP_ERASE) &&
                (state_r == eewr_pkg::EEWR_STROBE || state_r == eewr_pkg::EEWR_TIMED);
            mem_we_n_out <= !(state_r == eewr_pkg::EEWR_STROBE || state_r == eewr_pkg::EEWR_TIMED);
            mem_data_oe_out <= (state_r == eewr_pkg::EEWR_STROBE || state_r == eewr_pkg::EEWR_TIMED);
            mem_ce_n_out <= !(state_r == eewr_pkg::EEWR_STROBE || state_r == eewr_pkg::EEWR_TIMED ||
                state_r == eewr_pkg::EEWR_READ);
            mem_oe_n_out <= (state_r != eewr_pkg::EEWR_READ);
        end
    end

    // User answers
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            req_ready_out <= 1'b0;
            done_out <= 1'b0;
            write_done_out <= 1'b0;
            rd_data_out <= '0;
        end
        else
        begin
            req_ready_out <= (state_r == eewr_pkg::EEWR_IDLE) && ready_sync && !req_valid_in;
            done_out <= 1'b0;
            write_done_out <= 1'b0;
            if (state_r == eewr_pkg::EEWR_READ && cnt_r == CNT_W'(1))
            begin
                rd_data_out <= mem_data_in;
                done_out <= 1'b1;
            end
            if ((state_r == eewr_pkg::EEWR_WAIT_READY && ready_sync) ||
                (state_r == eewr_pkg::EEWR_TIMED && cnt_r == CNT_W'(1)) ||
                (state_r == eewr_pkg::EEWR_WAIT_BUSY && ready_sync && cnt_r == '0))
            begin
                done_out <= 1'b1;
                write_done_out <= 1'b1;
            end
        end
    end
endmodule

/* File: eewr_host_monitor.sv */
// Checker on the host write controller pins
`timescale 1ns/100ps
module eewr_host_monitor #(
    parameter int WRITE_CYC = 50
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic self_timed_in,
    input wire logic write_done_out,
    input wire logic mem_ce_n_out,
    input wire logic mem_we_n_out,
    input wire logic mem_ready_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    int lo_cnt;
    // Strobe low time, saturating so it never wraps
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            lo_cnt <= 0;
        else if (mem_we_n_out)
            lo_cnt <= 0;
        else if (lo_cnt < WRITE_CYC + 9)
            lo_cnt <= lo_cnt + 1;
    end
    // Ready seen high long enough to pass the synchroniser
    sequence s_rdy;
        $past(mem_ready_in, 3) && mem_ready_in;
    endsequence
    sequence s_we10;
        !mem_we_n_out [*5] ##1 !mem_we_n_out [*5] ##1 mem_we_n_out;
    endsequence
    a_start_on_ready: assert property ($fell(mem_ce_n_out) |-> s_rdy)
        else $error("access began while device busy");
    a_done_after_ready: assert property (write_done_out && !self_timed_in |-> s_rdy)
        else $error("write done without ready high");
    a_strobe_ten: assert property ($fell(mem_we_n_out) && !self_timed_in |-> s_we10)
        else $error("write strobe length wrong");
    a_timed_pulse: assert property ($rose(mem_we_n_out) && self_timed_in |-> lo_cnt >= WRITE_CYC)
        else $error("timed write pulse too short");
endmodule
bind eewr_host eewr_host_monitor #(.WRITE_CYC(WRITE_CYC)) u_mon (.mclk_in, .sys_rst_in, .self_timed_in,
    .write_done_out, .mem_ce_n_out, .mem_we_n_out, .mem_ready_in);

/* File: eewr_mem_model.sv */
// Behavioural self-sequencing byte-wide memory
`timescale 1ns/100ps
module eewr_mem_model #(
    parameter int BUSY_CYC = 20
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [10:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic ce_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic erase_in,
    output logic ready_out,
    output logic [7:0] data_out
);
    logic [7:0] mem [0:2047];
    logic [10:0] addr_r;
    logic [7:0] data_r;
    logic erase_r, we_n_r;
    int cnt_r;
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ready_out <= 1'b1;
            we_n_r <= 1'b1;
        end
        else
        begin
            we_n_r <= we_n_in;
            if (ready_out && !ce_n_in && !we_n_in && we_n_r)
            begin
                {addr_r, data_r, erase_r} <= {addr_in, data_in, erase_in};
                cnt_r <= addr_in[0] ? 2 * BUSY_CYC : BUSY_CYC; // Slow and prompt
                ready_out <= 1'b0;
            end
            else if (!ready_out)
            begin
                cnt_r <= cnt_r - 1;
                if (cnt_r == BUSY_CYC / 2)
                    mem[addr_r] <= 8'hFF;
                if (cnt_r == 1)
                begin
                    ready_out <= 1'b1;
                    for (int i = 0; i < 2048; i++)
                        if (erase_r || i == int'(addr_r))
                            mem[i] <= erase_r ? 8'hFF : data_r;
                end
            end
        end
    end
    // drive only when ready; a floating bus toggles
    always_ff @(posedge mclk_in)
        data_out <= (ready_out && !ce_n_in && !oe_n_in) ? mem[addr_in] : ~data_out;
endmodule

/* File: eewr_host_test.sv */
// Self-checking bench for the host write controller
`timescale 1ns/100ps
module eewr_host_test;
    localparam int WCYC = 50;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic self_timed_in = 1'b0;
    logic [1:0] req_op_in = 2'h0;
    logic [10:0] req_addr_in = 11'h000;
    logic [10:0] ma;
    logic [7:0] req_data_in = 8'h00;
    logic [7:0] rd_data_out, dq_h, dq_d, mem_data_in;
    logic done_out, write_done_out, req_ready_out, oe, ce_n, we_n, oe_n, er, rdy;
    logic [7:0] sh [0:2047];
    int err_count = 0;
    int n_checks = 0;
    int seed = 32'hAD9B;
    int lat;
    always #5 mclk_in = ~mclk_in;
    assign mem_data_in = oe ? dq_h : dq_d;
    eewr_host #(.WRITE_CYC(WCYC)) u_dut (.mclk_in, .sys_rst_in, .req_valid_in, .req_op_in, .req_addr_in,
        .req_data_in, .self_timed_in, .req_ready_out, .done_out, .rd_data_out, .write_done_out,
        .mem_addr_out(ma), .mem_data_out(dq_h), .mem_data_oe_out(oe), .mem_data_in, .mem_ce_n_out(ce_n),
        .mem_we_n_out(we_n), .mem_oe_n_out(oe_n), .mem_erase_out(er), .mem_ready_in(rdy));
    eewr_mem_model u_mem (.mclk_in, .sys_rst_in, .addr_in(ma), .data_in(dq_h), .ce_n_in(ce_n),
        .we_n_in(we_n), .oe_n_in(oe_n), .erase_in(er), .ready_out(rdy), .data_out(dq_d));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until done; lat counts edges from the take
    task automatic run(input logic [1:0] op, input logic [10:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk_in);
        {req_op_in, req_addr_in, req_data_in, req_valid_in} <= {op, a, d, 1'b1};
        #1;
        // Idle with ready seen and no request at the edge just passed
        chk("req_ready", 8'h01, {7'h00, req_ready_out});
        for (n = 0; n < 3000 && done_out !== 1'b1; n++)
            @(posedge mclk_in) #1;
        req_valid_in <= 1'b0;
        lat = n - 1;
        // A run that hits the limit without done counts as a mismatch here
        chk("done_out", 8'h01, {7'h00, done_out});
        if (op == eewr_pkg::OP_READ)
            chk("rd_data", sh[a], rd_data_out);
        else
            chk("write_done", 8'h01, {7'h00, write_done_out});
        if (op == eewr_pkg::OP_WRITE)
            sh[a] = d;
        if (op == eewr_pkg::OP_CHIP_ERASE)
            foreach (sh[i])
                sh[i] = 8'hFF;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence: corners, random traffic, erase, timed variant
    initial
    begin
        logic [10:0] a;
        foreach (sh[i])
            sh[i] = 8'hFF;
        repeat (5) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        run(eewr_pkg::OP_WRITE, 11'h000, 8'h00);
        run(eewr_pkg::OP_READ, 11'h000, 8'h00);
        run(eewr_pkg::OP_WRITE, 11'h7FF, 8'hA5);
        run(eewr_pkg::OP_WRITE, 11'h7FF, 8'h5A);
        run(eewr_pkg::OP_READ, 11'h7FF, 8'h00);
        chk("rd_lat", 8'h04, lat[7:0]);
        repeat (6)
        begin
            a = 11'($random(seed));
            run(eewr_pkg::OP_WRITE, a, 8'($random(seed)));
            run(eewr_pkg::OP_READ, a, 8'h00);
        end
        run(eewr_pkg::OP_CHIP_ERASE, 11'h000, 8'h00);
        run(eewr_pkg::OP_READ, a, 8'h00);
        self_timed_in <= 1'b1;
        run(eewr_pkg::OP_WRITE, 11'h123, 8'h3C);
        chk("timed_lat", 8'(eewr_pkg::STROBE_CYC + WCYC), lat[7:0]);
        // Mode held past the strobe release so the checker sees the timed pulse end
        repeat (2) @(posedge mclk_in);
        self_timed_in <= 1'b0;
        run(eewr_pkg::OP_READ, 11'h123, 8'h00);
        print_verdict();
    end
    // Watchdog, about forty times the expected run of roughly 5 us
    initial
    begin
        #200000;
        err_count++;
        print_verdict();
    end
endmodule
